// >>> logic/ptb_time_base.sv
// Summary of operation
// - Free-running: count up, wrap after period match
// - Single-shot: wrap at match, clear run enable
// - Up/down: after period match count downward
// - Read-only down flag in control one
// - Output goes active on downward duty match
// - Up/down: outputs inactive until first downward count
// - Fosc/4 prescaled by 1, 4, 16, 64
// - Counter or control writes clear prescaler
// - Control writes leave counter untouched
`default_nettype none
module ptb_time_base import ptb_pkg::*; (
    // Clock, enable, reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Compare outputs
    output logic [NCH-1:0] pwm_out
);
    ptb_state_t s_r;
    ptb_state_t s_nxt;
    logic tick;
    logic presc_clr;
    logic wr_go;
    logic step;
    logic updown;
    logic boundary;
    logic [NCH-1:0] out_step;

    assign wr_go = write && s_r.ack;
    assign step = tick && s_r.run;
    assign updown = s_r.mode == PTB_UPDOWN || s_r.mode == PTB_UPDOWN_DBL;
    // Any counter or control write restarts the prescaler
    assign presc_clr = wr_go && (address == OFF_CNT || address == OFF_CTL0
        || address == OFF_CTL1);

    ptb_prescaler u_pre (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .clr(presc_clr),
        .sel(s_r.psel),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Per-channel compare, evaluated on the count before the step
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_comb begin
                out_step[g] = s_r.out[g];
                if (updown) begin
                    if (s_r.down && s_r.cnt == s_r.duty_act[g]) begin
                        out_step[g] = 1'b1;
                    end else if (!s_r.down && s_r.cnt == s_r.duty_act[g]) begin
                        out_step[g] = 1'b0;
                    end
                end else begin
                    out_step[g] = s_r.cnt < s_r.duty_act[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        boundary = 1'b0;
        if (step) begin
            s_nxt.out = out_step;
            if (!updown) begin
                if (s_r.cnt == s_r.per_act) begin
                    s_nxt.cnt = CNT_RST;
                    boundary = 1'b1;
                    if (s_r.mode == PTB_SINGLE) begin
                        s_nxt.run = 1'b0;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end else if (!s_r.down) begin
                if (s_r.cnt == s_r.per_act && s_r.per_act != CNT_RST) begin
                    s_nxt.down = 1'b1;
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end else if (s_r.cnt != s_r.per_act) begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                end
            end else if (s_r.cnt == CNT_RST) begin
                s_nxt.down = 1'b0;
                s_nxt.cnt = s_r.cnt + 1'b1;
                boundary = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 1'b1;
            end
        end
        // Stopped time base drops outputs, so up/down starts inactive
        if (!s_r.run) begin
            s_nxt.out = '0;
            s_nxt.down = 1'b0;
        end
        // Leaving up/down mid-run must not leave a stale down flag
        if (!updown) begin
            s_nxt.down = 1'b0;
        end
        // Loading is allowed while stopped so a fresh start sees new values
        if ((boundary || !s_r.run) && !s_r.pcon1[PCON1_BUFFER_UPDATE_BLOCK_BIT]) begin
            s_nxt.per_act = s_r.per_buf;
            s_nxt.duty_act = s_r.duty_buf;
        end
        // Bus: first cycle captures read data, second completes
        s_nxt.ack = (read || write) && !s_r.ack;
        s_nxt.rdata = 32'h0000_0000;
        unique case (address)
            OFF_CTL0: s_nxt.rdata[7:0] = {s_r.run, 3'h0, s_r.psel, s_r.mode};
            OFF_CTL1: s_nxt.rdata[CTL1_DOWN_BIT] = s_r.down;
            OFF_CNT: s_nxt.rdata[CNT_W-1:0] = s_r.cnt;
            OFF_PER: s_nxt.rdata[CNT_W-1:0] = s_r.per_buf;
            OFF_PCON1: s_nxt.rdata[7:0] = s_r.pcon1;
            OFF_DUTY0: s_nxt.rdata[CNT_W-1:0] = s_r.duty_buf[0];
            OFF_DUTY1: s_nxt.rdata[CNT_W-1:0] = s_r.duty_buf[1];
            default: s_nxt.rdata = 32'h0000_0000;
        endcase
        if (s_r.ack) begin
            s_nxt.rdata = s_r.rdata;
        end
        if (wr_go) begin
            unique case (address)
                OFF_CTL0: begin
                    // Counter deliberately not touched here
                    s_nxt.run = writedata[CTL0_RUN_BIT];
                    s_nxt.psel = writedata[CTL0_PSEL_LSB +: 2];
                    s_nxt.mode = ptb_mode_t'(writedata[CTL0_MODE_LSB +: 2]);
                end
                OFF_CNT: s_nxt.cnt = writedata[CNT_W-1:0];
                OFF_PER: s_nxt.per_buf = writedata[CNT_W-1:0];
                OFF_PCON1: begin
                    s_nxt.pcon1 = writedata[7:0];
                    s_nxt.pcon1[PCON1_RSVD_BIT] = 1'b0;
                end
                OFF_DUTY0: s_nxt.duty_buf[0] = writedata[CNT_W-1:0];
                OFF_DUTY1: s_nxt.duty_buf[1] = writedata[CNT_W-1:0];
                default: s_nxt.pcon1 = s_nxt.pcon1;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.per_buf <= PER_RST;
            s_r.per_act <= PER_RST;
            s_r.pcon1 <= PCON1_RST;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign readdata = s_r.rdata;
    // Frozen clock enable must stall the bus, or a write would be lost
    assign waitrequest = (read || write) && !(s_r.ack && ce);
    assign pwm_out = s_r.out;

    ////////////////////////////////////////////////////////////////////////
    chk_free_wrap: assert property (@(posedge mclk) disable iff (!rstn)
        ce && step && s_r.mode == PTB_FREE && s_r.cnt == s_r.per_act && !wr_go
        |=> s_r.cnt == CNT_RST && s_r.run)
        else $error("free-running counter did not wrap");
    chk_single_stop: assert property (@(posedge mclk) disable iff (!rstn)
        ce && step && s_r.mode == PTB_SINGLE && s_r.cnt == s_r.per_act && !wr_go
        |=> s_r.cnt == CNT_RST && !s_r.run)
        else $error("single-shot did not stop");
    chk_turn_down: assert property (@(posedge mclk) disable iff (!rstn)
        ce && step && updown && !s_r.down && s_r.cnt == s_r.per_act
        && s_r.per_act != CNT_RST && !wr_go
        |=> s_r.down && s_r.cnt == $past(s_r.cnt) - 1'b1)
        else $error("no downward turn at period");
    chk_dir_read: assert property (@(posedge mclk) disable iff (!rstn)
        ce && read && s_r.ack && address == OFF_CTL1
        |-> readdata[CTL1_DOWN_BIT] == $past(s_r.down) && readdata[6:0] == 7'h00)
        else $error("direction flag misread");
    chk_down_set: assert property (@(posedge mclk) disable iff (!rstn)
        ce && step && updown && s_r.down && s_r.cnt == s_r.duty_act[0]
        |=> pwm_out[0])
        else $error("output not driven active on down match");
    chk_first_half: assert property (@(posedge mclk) disable iff (!rstn)
        ce && !s_r.run ##1 ce && updown && !s_r.down |=> pwm_out == '0)
        else $error("output active before first downward count");
    chk_ctl_keeps: assert property (@(posedge mclk) disable iff (!rstn)
        ce && wr_go && (address == OFF_CTL0 || address == OFF_CTL1) && !step
        |=> s_r.cnt == $past(s_r.cnt))
        else $error("control write changed counter");
    chk_bottom_up: assert property (@(posedge mclk) disable iff (!rstn)
        ce && step && updown && s_r.down && s_r.cnt == CNT_RST && !wr_go
        |=> !s_r.down && s_r.cnt == 12'h001)
        else $error("no upward turn at zero");
    chk_buffer_update_block_hold: assert property (@(posedge mclk) disable iff (!rstn)
        s_r.pcon1[PCON1_BUFFER_UPDATE_BLOCK_BIT]
        |=> s_r.duty_act == $past(s_r.duty_act) && s_r.per_act == $past(s_r.per_act))
        else $error("active values updated while blocked");
    chk_mode_flag: assert property (@(posedge mclk) disable iff (!rstn)
        ce && !updown |=> !s_r.down)
        else $error("direction flag set outside up/down");
    chk_up_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        ce && updown && !s_r.down && pwm_out == '0 |=> pwm_out == '0)
        else $error("output active during upward count");
    chk_ce_freeze: assert property (@(posedge mclk) disable iff (!rstn)
        !ce |=> s_r == $past(s_r))
        else $error("state changed while clock enable low");
    chk_wait_ce: assert property (@(posedge mclk) disable iff (!rstn)
        !ce && (read || write) |-> waitrequest)
        else $error("bus answered while clock enable low");
    chk_ack_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        ce && s_r.ack |=> !s_r.ack)
        else $error("bus answer held for more than one cycle");
endmodule
`default_nettype wire

// >>> logic/ptb_pkg.sv
`default_nettype none
package ptb_pkg;
    // Register byte addresses
    localparam logic [4:0] OFF_CTL0 = 5'h00;
    localparam logic [4:0] OFF_CTL1 = 5'h04;
    localparam logic [4:0] OFF_CNT = 5'h08;
    localparam logic [4:0] OFF_PER = 5'h0C;
    localparam logic [4:0] OFF_PCON1 = 5'h10;
    localparam logic [4:0] OFF_DUTY0 = 5'h14;
    localparam logic [4:0] OFF_DUTY1 = 5'h18;
    // Field positions
    localparam int CTL0_RUN_BIT = 7;
    localparam int CTL0_PSEL_LSB = 2;
    localparam int CTL0_MODE_LSB = 0;
    localparam int CTL1_DOWN_BIT = 7;
    localparam int PCON1_BUFFER_UPDATE_BLOCK_BIT = 1;
    localparam int PCON1_RSVD_BIT = 2;
    // Sizes
    localparam int CNT_W = 12;
    localparam int NCH = 2;
    // Reset values
    localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
    localparam logic [CNT_W-1:0] PER_RST = 12'hFFF;
    localparam logic [7:0] PCON1_RST = 8'h00;
    // Prescaler: Fosc/4 then 1:1, 1:4, 1:16, 1:64, as terminal counts
    localparam logic [7:0] PRE_LIM0 = 8'h03;
    localparam logic [7:0] PRE_LIM1 = 8'h0F;
    localparam logic [7:0] PRE_LIM2 = 8'h3F;
    localparam logic [7:0] PRE_LIM3 = 8'hFF;

    typedef enum logic [1:0] {
        PTB_FREE,
        PTB_SINGLE,
        PTB_UPDOWN,
        PTB_UPDOWN_DBL
    } ptb_mode_t;

    typedef struct packed {
        logic run;
        logic [1:0] psel;
        ptb_mode_t mode;
        logic [CNT_W-1:0] cnt;
        logic down;
        logic [CNT_W-1:0] per_buf;
        logic [CNT_W-1:0] per_act;
        logic [NCH-1:0][CNT_W-1:0] duty_buf;
        logic [NCH-1:0][CNT_W-1:0] duty_act;
        logic [7:0] pcon1;
        logic [NCH-1:0] out;
        logic ack;
        logic [31:0] rdata;
    } ptb_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } ptb_pre_t;
endpackage
`default_nettype wire

// >>> logic/ptb_prescaler.sv
`default_nettype none
module ptb_prescaler import ptb_pkg::*; (
    // Clock, enable and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Control
    input wire logic clr,
    input wire logic [1:0] sel,
    // Time base tick
    output logic tick
);
    ptb_pre_t s_r;
    ptb_pre_t s_nxt;
    logic [7:0] lim;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (sel)
            2'h0: lim = PRE_LIM0;
            2'h1: lim = PRE_LIM1;
            2'h2: lim = PRE_LIM2;
            2'h3: lim = PRE_LIM3;
        endcase
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (clr) begin
            s_nxt.cnt = 8'h00;
        end else if (s_r.cnt >= lim) begin
            // Compare with >= so a ratio cut mid-count cannot run to 255
            s_nxt.cnt = 8'h00;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

    ////////////////////////////////////////////////////////////////////////
    chk_presc_clear: assert property (@(posedge mclk) disable iff (!rstn)
        ce && clr |=> s_r.cnt == 8'h00 && !tick)
        else $error("prescaler not cleared");
    chk_presc_ratio: assert property (@(posedge mclk) disable iff (!rstn)
        ce && !clr && s_r.cnt == lim |=> tick)
        else $error("prescaler tick missing at terminal count");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ptb_pkg::*;
    logic mclk, rstn, ce, read, write, waitrequest;
    logic [4:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [NCH-1:0] pwm_out;
    int n_errors, compares;
    ////////////////////////////////////////////////////////////////////////
    ptb_time_base ptb_time_base_inst (.mclk(mclk), .rstn(rstn), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pwm_out(pwm_out));
    always #25 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Idle edge after release, so back to back requests never retoggle in one step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        rd = readdata;
        if (n >= 100) n_errors++;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rreg(input logic [4:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rreg(OFF_PER); check(rd, {20'h0, PER_RST});
        rreg(OFF_CTL0); check(rd, 32'h0);
        rreg(OFF_CNT); check(rd, 32'h0);
        wreg(OFF_CTL1, 32'h80);
        rreg(OFF_CTL1); check(rd, 32'h0);
        wreg(OFF_PCON1, 32'hFF);
        rreg(OFF_PCON1); check(rd, 32'hFB);
        wreg(5'h1C, 32'h5A);
        rreg(5'h1C); check(rd, 32'h0);
    endtask
    task automatic t_buffer_update_block();
        wreg(OFF_PCON1, 32'h02);
        wreg(OFF_PER, 32'h3);
        wreg(OFF_CTL0, 32'h80);
        repeat (40) @(posedge mclk);
        rreg(OFF_CNT); check(rd > 3, 1);
        wreg(OFF_CTL0, 32'h0);
        wreg(OFF_PCON1, 32'h0);
        wreg(OFF_CNT, 32'h0);
    endtask
    task automatic t_free();
        logic [31:0] prev;
        logic wrapped;
        prev = 0;
        wrapped = 0;
        wreg(OFF_CTL0, 32'h80);
        repeat (30) begin
            rreg(OFF_CNT); check(rd <= 3, 1);
            if (rd < prev) wrapped = 1;
            prev = rd;
        end
        check(wrapped, 1);
        wreg(OFF_CTL0, 32'h0);
    endtask
    task automatic t_single();
        wreg(OFF_CNT, 32'h0);
        wreg(OFF_PER, 32'h5);
        wreg(OFF_CTL0, 32'h81);
        repeat (60) @(posedge mclk);
        rreg(OFF_CTL0); check(rd[7], 0);
        rreg(OFF_CNT); check(rd, 32'h0);
    endtask
    // Sample mid-tick for 1:4 and up, so one cycle of tick skew cannot flip the result; at 1:1 it lands on the first cycle of count 3
    task automatic t_presc();
        int r;
        wreg(OFF_PER, 32'hFFF);
        wreg(OFF_CNT, 32'h7);
        wreg(OFF_CTL0, 32'h0C);
        wreg(OFF_CTL1, 32'h0);
        rreg(OFF_CNT); check(rd, 32'h7);
        for (int i = 0; i < 4; i++) begin
            r = 1 << (2 * i);
            wreg(OFF_CTL0, 32'h80 | (i << 2));
            wreg(OFF_CNT, 32'h0);
            repeat (12 * r + 2 * r - 2) @(posedge mclk);
            rreg(OFF_CNT); check(rd, 32'h3);
        end
        wreg(OFF_CTL0, 32'h0);
    endtask
    task automatic t_updown();
        int n;
        wreg(OFF_CNT, 32'h0);
        wreg(OFF_DUTY0, 32'h4);
        wreg(OFF_DUTY1, 32'h2);
        wreg(OFF_PER, 32'h8);
        wreg(OFF_CTL0, 32'h82);
        n = 0;
        do begin
            rreg(OFF_CTL1);
            n++;
            if (rd[7] !== 1'b1) check(pwm_out, 2'b00);
        end while (rd[7] !== 1'b1 && n < 100);
        rreg(OFF_CNT); check(rd >= 7 && rd <= 8, 1);
        n = 0;
        while (pwm_out !== 2'b11 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        check(pwm_out, 2'b11);
        rreg(OFF_CTL1); check(rd[7], 1);
        n = 0;
        do begin
            rreg(OFF_CTL1);
            n++;
        end while (rd[7] !== 1'b0 && n < 100);
        rreg(OFF_CNT); check(rd <= 2, 1);
        wreg(OFF_CTL0, 32'h0);
    endtask
    task automatic t_mode3();
        int n;
        wreg(OFF_CNT, 32'h0);
        wreg(OFF_PER, 32'h2);
        wreg(OFF_CTL0, 32'h83);
        rreg(OFF_CTL0); check(rd, 32'h83);
        n = 0;
        do begin
            rreg(OFF_CTL1);
            n++;
        end while (rd[7] !== 1'b1 && n < 100);
        check(rd[7], 1);
        // Reset in mid-run must bring back idle defaults
        rstn <= 1'b0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        rreg(OFF_CTL0); check(rd, 32'h0);
        rreg(OFF_PER); check(rd, {20'h0, PER_RST});
        rreg(OFF_CTL1); check(rd, 32'h0);
    endtask
    // Read issued while frozen must stall, and the count must not move
    task automatic t_freeze();
        wreg(OFF_CNT, 32'h0);
        wreg(OFF_CTL0, 32'h80);
        ce <= 1'b0;
        fork
            begin
                repeat (50) @(posedge mclk);
                ce <= 1'b1;
            end
        join_none
        rreg(OFF_CNT); check(rd, 32'h0);
        wreg(OFF_CTL0, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        mclk = 0;
        rstn = 0;
        ce = 1;
        read = 0;
        write = 0;
        address = 0;
        writedata = 0;
        n_errors = 0;
        compares = 0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_buffer_update_block();
        t_free();
        t_single();
        t_presc();
        t_updown();
        t_mode3();
        t_freeze();
        stop_test();
    end
    // Whole run needs under two thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
